/* File: trace_capture_pkg.sv */
package trace_capture_pkg;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US = 200;
  localparam int TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;

  // -------------------------------------------------------------------------
  // sample memory sizing and reset values
  // -------------------------------------------------------------------------
  localparam int TRACE_MEM_BYTES = 15360;
  localparam int POINT_BYTES = 2;
  localparam int TRACE_DEPTH = TRACE_MEM_BYTES / POINT_BYTES;
  localparam int PCT_FULL = 100;
  localparam logic [15:0] START_RESET = 16'h0000;
  localparam logic [15:0] STAMP_RESET = 16'h0000;
  localparam logic [15:0] START_ON = 16'h0001;

  // -------------------------------------------------------------------------
  // trigger condition codes and capture states
  // -------------------------------------------------------------------------
  localparam logic [2:0] COND_EQ = 3'h0;
  localparam logic [2:0] COND_NE = 3'h1;
  localparam logic [2:0] COND_GT = 3'h2;
  localparam logic [2:0] COND_LT = 3'h3;
  localparam logic [2:0] COND_ALARM = 3'h4;
  localparam logic [2:0] COND_FAULT = 3'h5;
  localparam logic [2:0] COND_DIN = 3'h6;

  typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_TRIG, ST_DONE} trace_state_t;

endpackage

/* File: trace_mem_if.sv */
`timescale 1ns/100ps
interface trace_mem_if #(parameter int ADDR_W = 13, parameter int DATA_W = 16);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: trace_sample_ram.sv */
`timescale 1ns/100ps
module trace_sample_ram
  import trace_capture_pkg::*;
#(
  parameter int DEPTH = TRACE_DEPTH
)
(
  input wire logic i_ref_clk,
  trace_mem_if.mem mem
);

  // -------------------------------------------------------------------------
  // plain volatile array, no reset so contents are lost at power-off
  // -------------------------------------------------------------------------
  logic [$bits(mem.wr_data)-1:0] store [DEPTH];
  logic [$bits(mem.rd_data)-1:0] rd_q;

  always_ff @(posedge i_ref_clk)
  begin
    if (mem.wr_en)
    begin
      store[mem.wr_addr] <= mem.wr_data; // RQ6
    end
    rd_q <= store[mem.rd_addr];
  end

  assign mem.rd_data = rd_q;

endmodule

/* File: trace_capture_control.sv */
// Notes on behaviour
// [RQ1] writing 1 to trace_start arms the capture to wait for the trigger, 0 leaves it idle, reset value 0.
// [RQ2] a write to trace_start acts in the next cycle with no separate save step, motor running or not.
// [RQ3] an arming write is ignored while no channel is active or the available memory reads zero.
// [RQ4] any change of a trace configuration setting clears trace_start to 0.
// [RQ5] at the trigger the day/month, year, hour:minute and second of the keypad clock are latched.
// [RQ6] the timestamp and the sample points live only in volatile storage.
// [RQ7] the timestamp reads zero before any capture since power-up or when no clock source was present.
// [RQ8] trace_status shows 0 off, 1 waiting, 2 triggered, 3 concluded.
// [RQ9] status goes off to waiting on arming, waiting to triggered on the trigger, triggered to concluded when full;
// the code goes from waiting straight to concluded at the trigger when the pretrigger share is 100%.
// [RQ10] the trigger is a compare (=, !=, >, <) of the chosen variable with a set value, an alarm, a fault or an input.
// [RQ11] samples are spaced by sample_period times a 200 us base tick.
// [RQ12] the pretrigger share of the buffer holds samples taken before the trigger.
`timescale 1ns/100ps
module trace_capture_control
  import trace_capture_pkg::*;
#(
  parameter int DEPTH = TRACE_DEPTH,
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int ADDR_W = $clog2(DEPTH)
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_start_wr,
  input wire logic [15:0] i_start_wdata,
  input wire logic i_cfg_wr,
  input wire logic [2:0] i_trigger_condition_select,
  input wire logic [15:0] i_trigger_variable,
  input wire logic [15:0] i_trigger_compare_value,
  input wire logic [15:0] i_sample_period,
  input wire logic [6:0] i_pretrigger_percent,
  input wire logic [3:0] i_channel_active,
  input wire logic [6:0] i_trace_available_memory,
  input wire logic i_alarm,
  input wire logic i_fault,
  input wire logic i_trace_din,
  input wire logic [15:0] i_sample_data,
  input wire logic i_rtc_present,
  input wire logic [7:0] i_rtc_day,
  input wire logic [7:0] i_rtc_month,
  input wire logic [7:0] i_rtc_year,
  input wire logic [7:0] i_rtc_hour,
  input wire logic [7:0] i_rtc_minute,
  input wire logic [7:0] i_rtc_second,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [15:0] o_trace_start,
  output logic [15:0] o_trace_day_month,
  output logic [15:0] o_trace_year,
  output logic [15:0] o_trace_hour,
  output logic [15:0] o_trace_second,
  output logic [15:0] o_trace_status,
  output logic [ADDR_W-1:0] o_trigger_addr,
  output logic [15:0] o_rd_data
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  localparam int TICK_W = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [15:0] start;
    trace_state_t st;
    logic [ADDR_W-1:0] wptr;
    logic [ADDR_W-1:0] trig_addr;
    logic [ADDR_W:0] post_cnt;
    logic [TICK_W-1:0] tick;
    logic [15:0] per_cnt;
    logic [15:0] day_month;
    logic [15:0] year;
    logic [15:0] hour;
    logic [15:0] second;
  } ctl_t;

  ctl_t s;
  ctl_t next_s;

  trace_mem_if #(.ADDR_W(ADDR_W), .DATA_W(16)) mem_bus ();

  trace_sample_ram #(.DEPTH(DEPTH)) u_ram (
    .i_ref_clk(i_ref_clk),
    .mem(mem_bus.mem)
  );

  // -------------------------------------------------------------------------
  // trigger, timebase and buffer split
  // -------------------------------------------------------------------------
  logic arm_blocked;
  logic trig_hit;
  logic sample_stb;
  logic [ADDR_W+7:0] pre_prod;
  logic [ADDR_W:0] pre_pts;
  logic [ADDR_W:0] post_need;
  logic [15:0] period;
  logic [6:0] pct;

  assign arm_blocked = (i_channel_active == 4'h0) || (i_trace_available_memory == 7'h00); // RQ3
  assign period = (i_sample_period == 16'h0000) ? 16'h0001 : i_sample_period;
  assign pct = (i_pretrigger_percent > 7'(PCT_FULL)) ? 7'(PCT_FULL) : i_pretrigger_percent;
  assign pre_prod = (ADDR_W + 8)'(DEPTH) * (ADDR_W + 8)'(pct);
  assign pre_pts = (ADDR_W + 1)'(pre_prod / (ADDR_W + 8)'(PCT_FULL)); // RQ12
  assign post_need = (ADDR_W + 1)'(DEPTH) - pre_pts; // RQ12
  assign sample_stb = (s.tick == TICK_W'(0)) && (s.per_cnt == period - 16'h0001); // RQ11

  always_comb
  begin
    case (i_trigger_condition_select) // RQ10
      COND_EQ: trig_hit = (i_trigger_variable == i_trigger_compare_value);
      COND_NE: trig_hit = (i_trigger_variable != i_trigger_compare_value);
      COND_GT: trig_hit = (i_trigger_variable > i_trigger_compare_value);
      COND_LT: trig_hit = (i_trigger_variable < i_trigger_compare_value);
      COND_ALARM: trig_hit = i_alarm;
      COND_FAULT: trig_hit = i_fault;
      COND_DIN: trig_hit = i_trace_din;
      default: trig_hit = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    if (s.st == ST_WAIT || s.st == ST_TRIG)
    begin
      next_s.tick = (s.tick == TICK_W'(0)) ? TICK_W'(TICK_CYC - 1) : s.tick - TICK_W'(1); // RQ11
      if (s.tick == TICK_W'(0))
      begin
        next_s.per_cnt = sample_stb ? 16'h0000 : s.per_cnt + 16'h0001;
      end
      if (sample_stb)
      begin
        next_s.wptr = (s.wptr == ADDR_W'(DEPTH - 1)) ? '0 : s.wptr + ADDR_W'(1);
      end
    end
    case (s.st)
      ST_OFF: ;
      ST_WAIT:
      begin
        if (trig_hit) // RQ9
        begin
          next_s.st = (post_need == '0) ? ST_DONE : ST_TRIG;
          next_s.trig_addr = s.wptr;
          next_s.post_cnt = '0;
          if (i_rtc_present) // RQ5
          begin
            next_s.day_month = {i_rtc_day, i_rtc_month};
            next_s.year = {8'h00, i_rtc_year};
            next_s.hour = {i_rtc_hour, i_rtc_minute};
            next_s.second = {8'h00, i_rtc_second};
          end
          else
          begin
            next_s.day_month = STAMP_RESET; // RQ7
            next_s.year = STAMP_RESET;
            next_s.hour = STAMP_RESET;
            next_s.second = STAMP_RESET;
          end
        end
      end
      ST_TRIG:
      begin
        if (sample_stb)
        begin
          next_s.post_cnt = s.post_cnt + (ADDR_W + 1)'(1);
          if (s.post_cnt + (ADDR_W + 1)'(1) >= post_need) // RQ9
          begin
            next_s.st = ST_DONE;
          end
        end
      end
      ST_DONE: ;
      default: next_s.st = ST_OFF;
    endcase
    if (i_start_wr) // RQ2
    begin
      if (i_start_wdata == START_ON && !arm_blocked) // RQ1 RQ3
      begin
        next_s.start = START_ON;
        next_s.st = ST_WAIT;
        next_s.tick = TICK_W'(TICK_CYC - 1);
        next_s.per_cnt = 16'h0000;
        next_s.wptr = '0;
      end
      else if (i_start_wdata != START_ON)
      begin
        next_s.start = START_RESET;
        next_s.st = ST_OFF;
      end
    end
    if (i_cfg_wr) // RQ4
    begin
      next_s.start = START_RESET;
      next_s.st = ST_OFF;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      s <= '0; // RQ7
      s.start <= START_RESET;
      s.st <= ST_OFF;
    end
    else
    begin
      s <= next_s;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign mem_bus.wr_en = sample_stb && (s.st == ST_WAIT || s.st == ST_TRIG); // RQ12
  assign mem_bus.wr_addr = s.wptr;
  assign mem_bus.wr_data = i_sample_data;
  assign mem_bus.rd_addr = i_rd_addr;
  assign o_rd_data = mem_bus.rd_data;
  assign o_trace_start = s.start;
  assign o_trace_status = 16'(s.st); // RQ8
  assign o_trace_day_month = s.day_month;
  assign o_trace_year = s.year;
  assign o_trace_hour = s.hour;
  assign o_trace_second = s.second;
  assign o_trigger_addr = s.trig_addr;

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  logic quiet;
  logic [31:0] gap;
  logic gap_ok;
  assign quiet = !i_start_wr && !i_cfg_wr;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b || !(s.st == ST_WAIT || s.st == ST_TRIG) || !quiet)
    begin
      gap <= 32'h0000_0001;
      gap_ok <= 1'b0;
    end
    else if (mem_bus.wr_en)
    begin
      gap <= 32'h0000_0001;
      gap_ok <= 1'b1;
    end
    else
    begin
      gap <= gap + 32'h0000_0001;
    end
  end

  chk_arm_waits: assert property (i_start_wr && i_start_wdata == START_ON && !arm_blocked && !i_cfg_wr
    |=> o_trace_status == 16'h0001 && o_trace_start == START_ON) else $error("arming did not start wait"); // RQ1
  chk_arm_ignored: assert property (i_start_wr && i_start_wdata == START_ON && arm_blocked && !i_cfg_wr
    && o_trace_status == 16'h0000 |=> o_trace_status == 16'h0000 && o_trace_start == START_RESET)
    else $error("blocked arming took effect"); // RQ3
  chk_cfg_clears: assert property (i_cfg_wr |=> o_trace_start == START_RESET && o_trace_status == 16'h0000)
    else $error("config change did not clear start"); // RQ4
  chk_ts_latch: assert property (s.st == ST_WAIT && trig_hit && quiet && i_rtc_present
    |=> o_trace_second == {8'h00, $past(i_rtc_second)} && o_trace_hour == {$past(i_rtc_hour), $past(i_rtc_minute)})
    else $error("timestamp not latched at trigger"); // RQ5
  chk_ts_no_rtc: assert property (s.st == ST_WAIT && trig_hit && quiet && !i_rtc_present
    |=> o_trace_day_month == 16'h0000 && o_trace_second == 16'h0000) else $error("timestamp not zero"); // RQ7
  chk_reset_clear: assert property (disable iff (1'b0) !i_rst_b |=> o_trace_year == 16'h0000
    && o_trace_status == 16'h0000 && o_trace_start == START_RESET) else $error("reset left state"); // RQ6
  chk_status_order: assert property (o_trace_status == 16'h0002 && quiet |=> o_trace_status == 16'h0002
    || o_trace_status == 16'h0003) else $error("illegal status move"); // RQ8
  chk_trig_eq: assert property (s.st == ST_WAIT && quiet && i_trigger_condition_select == COND_EQ
    && i_trigger_variable == i_trigger_compare_value |=> o_trace_status != 16'h0001)
    else $error("equal trigger missed"); // RQ10
  chk_sample_gap: assert property (mem_bus.wr_en && gap_ok
    |-> gap == 32'(period) * 32'(TICK_CYC)) else $error("sample spacing wrong"); // RQ11
  chk_conclude_full: assert property (s.st == ST_TRIG && sample_stb && quiet
    && s.post_cnt + (ADDR_W + 1)'(1) == post_need |=> o_trace_status == 16'h0003)
    else $error("buffer full but not concluded"); // RQ9

  cov_armed: cover property (o_trace_status == 16'h0001);
  cov_triggered: cover property (o_trace_status == 16'h0001 ##1 o_trace_status == 16'h0002);
  cov_concluded: cover property (o_trace_status == 16'h0002 ##1 o_trace_status == 16'h0003);
  cov_cfg_abort: cover property (o_trace_status == 16'h0002 && i_cfg_wr);

endmodule

/* File: trace_keypad_rtc.sv */
`timescale 1ns/100ps
module trace_keypad_rtc
  import trace_capture_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_connect,
  output logic o_present,
  output logic [7:0] o_day,
  output logic [7:0] o_month,
  output logic [7:0] o_year,
  output logic [7:0] o_hour,
  output logic [7:0] o_minute,
  output logic [7:0] o_second
);
  // -------------------------------------------------------------------------
  // keypad clock: calendar at its upper limits, seconds run every 16 cycles
  // -------------------------------------------------------------------------
  logic [3:0] div = 4'h0;
  logic [5:0] sec_q = 6'h3A;
  logic [5:0] min_q = 6'h3B;
  logic [47:0] shown = 48'h0;
  logic present_q = 1'b0;

  always_ff @(posedge i_ref_clk)
  begin
    div <= div + 4'h1;
    if (div == 4'hF)
    begin
      sec_q <= (sec_q == 6'h3B) ? 6'h00 : sec_q + 6'h01;
      if (sec_q == 6'h3B)
        min_q <= (min_q == 6'h3B) ? 6'h00 : min_q + 6'h01;
    end
    present_q <= i_connect;
    // unplugged keypad: lines toggle every cycle instead of holding
    shown <= i_connect ? {8'h1F, 8'h0C, 8'h63, 8'h17, 2'b00, min_q, 2'b00, sec_q} : ~shown;
  end

  assign o_present = present_q;
  assign {o_day, o_month, o_year, o_hour, o_minute, o_second} = shown;
endmodule

/* File: trace_capture_control_test.sv */
`timescale 1ns/100ps
module trace_capture_control_test
  import trace_capture_pkg::*;
;
  typedef struct {int kind; logic [63:0] exp;} note_t;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_start_wr = 1'b0, i_cfg_wr = 1'b0;
  logic [15:0] i_start_wdata = 16'h0, i_trigger_variable = 16'h0, i_trigger_compare_value = 16'h0;
  logic [15:0] i_sample_period = 16'h1, i_sample_data = 16'h0;
  logic [2:0] i_trigger_condition_select = 3'h7;
  logic [6:0] i_pretrigger_percent = 7'h0, i_trace_available_memory = 7'h64;
  logic [3:0] i_channel_active = 4'h1, i_rd_addr = 4'h0;
  logic i_alarm = 1'b0, i_fault = 1'b0, i_trace_din = 1'b0, rtc_connect = 1'b1, span_ok = 1'b0;
  logic rtc_present;
  logic [7:0] rtc_day, rtc_month, rtc_year, rtc_hour, rtc_minute, rtc_second;
  logic [15:0] o_trace_start, o_trace_day_month, o_trace_year, o_trace_hour, o_trace_second, o_trace_status;
  logic [3:0] o_trigger_addr;
  logic [15:0] o_rd_data;
  int error_cnt = 0, cmp_count = 0;
  localparam int DEPTH_T = 16;
  localparam int TICK_T = 4;
  // sample word seen by the design at every edge, indexed by edge count
  logic [15:0] hist [1024];
  int now_cyc = 0;
  note_t notes[$];
  note_t n;
  event look;

  initial forever #5 i_ref_clk = ~i_ref_clk;

  trace_capture_control #(.DEPTH(DEPTH_T), .TICK_CYC(TICK_T)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_start_wr(i_start_wr), .i_start_wdata(i_start_wdata), .i_cfg_wr(i_cfg_wr),
    .i_trigger_condition_select(i_trigger_condition_select), .i_trigger_variable(i_trigger_variable),
    .i_trigger_compare_value(i_trigger_compare_value), .i_sample_period(i_sample_period),
    .i_pretrigger_percent(i_pretrigger_percent), .i_channel_active(i_channel_active),
    .i_trace_available_memory(i_trace_available_memory), .i_alarm(i_alarm), .i_fault(i_fault),
    .i_trace_din(i_trace_din), .i_sample_data(i_sample_data), .i_rtc_present(rtc_present),
    .i_rtc_day(rtc_day), .i_rtc_month(rtc_month), .i_rtc_year(rtc_year), .i_rtc_hour(rtc_hour),
    .i_rtc_minute(rtc_minute), .i_rtc_second(rtc_second), .i_rd_addr(i_rd_addr),
    .o_trace_start(o_trace_start), .o_trace_day_month(o_trace_day_month), .o_trace_year(o_trace_year),
    .o_trace_hour(o_trace_hour), .o_trace_second(o_trace_second), .o_trace_status(o_trace_status),
    .o_trigger_addr(o_trigger_addr), .o_rd_data(o_rd_data));

  trace_keypad_rtc keypad_u (.i_ref_clk(i_ref_clk), .i_connect(rtc_connect), .o_present(rtc_present),
    .o_day(rtc_day), .o_month(rtc_month), .o_year(rtc_year), .o_hour(rtc_hour), .o_minute(rtc_minute),
    .o_second(rtc_second));

  // -------------------------------------------------------------------------
  // checking
  // -------------------------------------------------------------------------
  task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  always
  begin
    @(look);
    #1;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        0: check_val("trace_start", n.exp, {48'h0, o_trace_start});
        1: check_val("trace_status", n.exp, {48'h0, o_trace_status});
        2: check_val("timestamp", n.exp, {o_trace_day_month, o_trace_year, o_trace_hour, o_trace_second});
        4: check_val("trigger_addr", n.exp, {60'h0, o_trigger_addr});
        5: check_val("rd_data", n.exp, {48'h0, o_rd_data});
        default: check_val("sample_span", n.exp, {63'h0, span_ok});
      endcase
    end
  end

  task automatic final_report;
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // stimulus
  // -------------------------------------------------------------------------
  always @(posedge i_ref_clk)
  begin
    hist[now_cyc % 1024] <= i_sample_data;
    now_cyc <= now_cyc + 1;
    i_sample_data <= 16'($urandom);
  end

  task automatic note(input int kind, input logic [63:0] exp);
    notes.push_back('{kind, exp});
  endtask

  task automatic show;
    ->look;
    @(posedge i_ref_clk);
  endtask

  task automatic start_wr(input logic [15:0] v);
    i_start_wr <= 1'b1;
    i_start_wdata <= v;
    @(posedge i_ref_clk);
    i_start_wr <= 1'b0;
  endtask

  task automatic cfg_pulse;
    i_cfg_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_cfg_wr <= 1'b0;
  endtask

  task automatic set_cond(input logic [2:0] code, input logic t, input logic [15:0] c);
    i_alarm <= t && code == COND_ALARM;
    i_fault <= t && code == COND_FAULT;
    i_trace_din <= t && code == COND_DIN;
    case (code)
      COND_EQ: i_trigger_variable <= t ? c : c + 16'h1;
      COND_NE: i_trigger_variable <= t ? c - 16'h1 : c;
      COND_GT: i_trigger_variable <= t ? c + 16'h1 : c;
      COND_LT: i_trigger_variable <= t ? c - 16'h1 : c;
      default: i_trigger_variable <= c;
    endcase
  endtask

  task automatic read_chk(input int a, input logic [15:0] exp);
    i_rd_addr <= 4'(a);
    @(posedge i_ref_clk);
    note(5, {48'h0, exp});
    show();
  endtask

  task automatic run_trig(input logic [2:0] code, input logic [6:0] pct, input logic pres);
    logic [15:0] c;
    int cyc;
    int per;
    int arm;
    int m;
    int post;
    c = 16'($urandom_range(1, 65534));
    per = (int'(code[0]) + 1) * TICK_T;
    m = $urandom_range(1, 3);
    post = DEPTH_T - (DEPTH_T * int'(pct)) / 100;
    i_trigger_condition_select <= code;
    i_trigger_compare_value <= c;
    set_cond(code, 1'b0, c);
    i_pretrigger_percent <= pct;
    i_sample_period <= 16'(code[0]) + 16'h1;
    rtc_connect <= pres;
    start_wr(START_ON);
    arm = now_cyc;
    note(1, 64'h1);
    show();
    // m samples land before the trigger, so the trigger address is m
    repeat (m * per) @(posedge i_ref_clk);
    set_cond(code, 1'b1, c);
    @(posedge i_ref_clk);
    note(2, rtc_present ? {rtc_day, rtc_month, 8'h00, rtc_year, rtc_hour, rtc_minute, 8'h00, rtc_second} : 64'h0);
    note(1, (post == 0) ? 64'h3 : 64'h2);
    note(4, 64'(m));
    show();
    cyc = 1;
    while (o_trace_status !== 16'h3 && cyc < 300)
    begin
      @(posedge i_ref_clk);
      cyc++;
    end
    // post samples after the trigger, one every per cycles
    span_ok = (post == 0) ? (cyc == 1) : (cyc == post * per - 1);
    note(3, 64'h1);
    note(1, 64'h3);
    show();
    for (int j = m + 1; j <= m + post; j++)
      read_chk((j - 1) % DEPTH_T, hist[(arm + j * per) % 1024]);
    cfg_pulse();
    note(1, 64'h0);
    show();
  endtask

  initial
  begin
    void'($urandom(48));
    repeat (12) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    note(0, 64'h0);
    note(1, 64'h0);
    note(2, 64'h0);
    show();
    i_channel_active <= 4'h0;
    start_wr(START_ON);
    note(0, 64'h0);
    show();
    i_channel_active <= 4'h8;
    i_trace_available_memory <= 7'h0;
    start_wr(START_ON);
    note(0, 64'h0);
    note(1, 64'h0);
    show();
    i_trace_available_memory <= 7'h64;
    start_wr(START_ON);
    note(0, 64'h1);
    note(1, 64'h1);
    show();
    start_wr(16'h0);
    note(0, 64'h0);
    show();
    start_wr(START_ON);
    show();
    cfg_pulse();
    note(0, 64'h0);
    show();
    i_cfg_wr <= 1'b1;
    start_wr(START_ON);
    i_cfg_wr <= 1'b0;
    note(0, 64'h0);
    show();
    for (int k = 0; k < 7; k++)
      run_trig(3'(k), 7'h32, k != 5);
    run_trig(COND_ALARM, 7'h64, 1'b1);
    run_trig(COND_FAULT, 7'h0, 1'b0);
    run_trig(COND_DIN, 7'h0, 1'b1);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    note(2, 64'h0);
    note(1, 64'h0);
    show();
    final_report();
  end

  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
endmodule
